// ---- common/pif_defines.svh ----
// Register map, field positions and reset values of the peripheral interrupt flag block
`ifndef PIF_DEFINES_SVH
`define PIF_DEFINES_SVH

`define PIF_OFF_FLAGS      8'h0c
`define PIF_OFF_ENABLES    8'h8c
`define PIF_OFF_IRQ_STATUS 8'h90
`define PIF_OFF_IRQ_ENABLE 8'h94
`define PIF_OFF_IRQ_CLEAR  8'h98
`define PIF_OFF_CORE_CTRL  8'h9c

`define PIF_BIT_TIMER_A    0
`define PIF_BIT_TIMER_B    1
`define PIF_BIT_CAPCMP     2
`define PIF_BIT_SYNC_SER   3
`define PIF_BIT_TX_EMPTY   4
`define PIF_BIT_RX_FULL    5
`define PIF_BIT_PERIPH_EN  6
`define PIF_BIT_GLOBAL_EN  7

`define PIF_SW_CLR_MASK    8'h0f
`define PIF_RESV_MASK      8'hc0
`define PIF_SERIAL_MASK    8'h30
`define PIF_REG_RESET      8'h00
`define PIF_RESP_OKAY      2'b00
`define PIF_RESP_SLVERR    2'b10

`endif

// ---- common/pif_pkg.sv ----
// Types shared by the peripheral interrupt flag block
package pif_pkg;
	typedef logic [7:0] pif_reg8_t;
endpackage

// ---- sim/pif_irq_checker.sv ----
// Port assertions for the peripheral interrupt flag block
`timescale 1ns/1ps
`include "pif_defines.svh"

module pif_irq_checker (
	// Clock and reset
	input wire logic        i_core_clk,
	input wire logic        i_resetn,
	// Register bus
	input wire logic        i_awvalid,
	input wire logic        o_awready,
	input wire logic        i_wvalid,
	input wire logic        o_wready,
	input wire logic [1:0]  o_bresp,
	input wire logic        o_bvalid,
	input wire logic        i_bready,
	input wire logic [7:0]  i_araddr,
	input wire logic        i_arvalid,
	input wire logic        o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0]  o_rresp,
	input wire logic        o_rvalid,
	input wire logic        i_rready,
	// Serial level
	input wire logic        i_serial_rx_full
);
	logic [7:0] rd_addr_ff;
	// ********************
	// Read in flight
	// ********************
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rd_addr_ff <= 8'h00;
		end else if (i_arvalid && o_arready) begin
			rd_addr_ff <= i_araddr;
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_wr_taken;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	a_wr_answer: assert property (s_wr_taken |-> ##2 o_bvalid)
		else $error("write answer late");
	a_bresp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write answer dropped");
	a_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read answer late");
	a_rdata_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read answer dropped");
	a_unmapped_rd: assert property (i_arvalid && o_arready && !(i_araddr inside
		{`PIF_OFF_FLAGS, `PIF_OFF_ENABLES, `PIF_OFF_IRQ_STATUS, `PIF_OFF_IRQ_ENABLE,
		`PIF_OFF_IRQ_CLEAR, `PIF_OFF_CORE_CTRL}) |=> o_rresp == 2'h2 && o_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_enable_narrow: assert property (
		o_rvalid && rd_addr_ff == `PIF_OFF_ENABLES |-> o_rdata[5:4] == 2'h0)
		else $error("enable high bits set");
	a_flag_resv: assert property (
		o_rvalid && rd_addr_ff == `PIF_OFF_FLAGS |-> o_rdata[7:6] == 2'h0)
		else $error("flag top bits set");
	a_rx_idle_flag: assert property (
		$rose(o_rvalid) && rd_addr_ff == `PIF_OFF_FLAGS && !$past(i_serial_rx_full)
		&& !$past(i_serial_rx_full, 2) |-> !o_rdata[5])
		else $error("receive flag without data");
endmodule // pif_irq_checker

bind pif_periph_irq pif_irq_checker pif_irq_checker_inst (
	.i_core_clk, .i_resetn, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp,
	.o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
	.o_rvalid, .i_rready, .i_serial_rx_full
);

// ---- sim/pif_periph_model.sv ----
// Peripheral side model: timer, capture/compare and sync serial event sources
`timescale 1ns/1ps

module pif_periph_model (
	// Clock
	input  wire logic       i_core_clk,
	// Event requests and answer delay
	input  wire logic [3:0] i_fire,
	input  wire logic [1:0] i_delay,
	// Event pulses in flag bit order
	output logic      [3:0] o_event
);
	logic [3:0] pend_ff [4];
	// ********************
	// Delay line
	// ********************
	always_ff @(posedge i_core_clk) begin
		pend_ff[0] <= i_fire;
		for (int k = 1; k < 4; k++) begin
			pend_ff[k] <= pend_ff[k - 1];
		end
	end
	// A slow answer moves the pulse later but never widens it
	assign o_event = pend_ff[i_delay];
endmodule // pif_periph_model

// ---- sim/tb.sv ----
// Register-level testbench for the peripheral interrupt flag block
`timescale 1ns/1ps
`include "pif_defines.svh"

module tb;
	localparam logic [7:0] FL = `PIF_OFF_FLAGS;
	localparam logic [7:0] EN = `PIF_OFF_ENABLES;
	localparam logic [7:0] CT = `PIF_OFF_CORE_CTRL;
	logic        clk = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, rx_full = 1'b0, tx_empty = 1'b0;
	logic        rx_rd = 1'b0, tx_wr = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  fire = 4'h0;
	logic [1:0]  dly = 2'h0;
	logic        awready, wready, bvalid, arready, rvalid, irq, evt_irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [3:0]  evt;
	int          fail_count = 0;
	int          total_checks = 0;
	pif_periph_irq pif_periph_irq_inst (.i_core_clk(clk), .i_resetn(resetn),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_timer_a_ovf(evt[0]), .i_timer_b_match(evt[1]),
		.i_capcmp_event(evt[2]), .i_sync_serial_done(evt[3]), .i_serial_rx_full(rx_full),
		.i_serial_tx_empty(tx_empty), .i_serial_rx_data_rd(rx_rd),
		.i_serial_tx_data_wr(tx_wr), .o_periph_irq(irq), .o_evt_irq(evt_irq));
	pif_periph_model pif_periph_model_inst (.i_core_clk(clk), .i_fire(fire),
		.i_delay(dly), .o_event(evt));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er = 2'b00);
		logic done;
		done = 1'b0;
		awaddr <= a;
		araddr <= a;
		wdata <= {24'h0, d};
		awvalid <= w;
		wvalid <= w;
		bready <= w;
		arvalid <= !w;
		rready <= !w;
		while (!done) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (arvalid && arready) arvalid <= 1'b0;
			if (bvalid || rvalid) begin
				done = 1'b1;
				bready <= 1'b0;
				rready <= 1'b0;
				chk(w ? bresp : rresp, er);
				if (!w) chk(rdata, {24'h0, d});
			end
		end
		@(posedge clk);
	endtask
	// Events and serial accesses are single-cycle strobes
	task automatic pulse(input logic [3:0] m, input int d);
		dly <= d[1:0];
		fire <= m;
		@(posedge clk);
		fire <= 4'h0;
		rx_rd <= 1'b0;
		tx_wr <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task automatic print_verdict();
		if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		acc(0, EN, 8'h00);
		acc(0, CT, 8'h00);
		pulse(4'hf, 0);
		acc(0, FL, 8'h0f);
		chk(irq, 1'b0);
		acc(1, FL, 8'h30);
		acc(0, FL, 8'h00);
		acc(1, EN, 8'h3f);
		acc(0, EN, 8'h0f);
		acc(1, CT, 8'hc0);
		for (int i = 0; i < 4; i++) begin
			acc(1, EN, 8'h01 << i);
			pulse(4'h1 << ((i + 1) % 4), i);
			chk(irq, 1'b0);
			pulse(4'h1 << i, 3 - i);
			acc(0, FL, 8'h01 << i | 8'h01 << ((i + 1) % 4));
			chk(irq, 1'b1);
			acc(1, CT, 8'h80);
			chk(irq, 1'b0);
			acc(1, CT, 8'h40);
			chk(irq, 1'b0);
			acc(1, CT, 8'hc0);
			chk(irq, 1'b1);
			acc(1, FL, 8'h00);
			chk(irq, 1'b0);
		end
		rx_full <= 1'b1;
		tx_empty <= 1'b1;
		pulse(4'h0, 0);
		acc(1, FL, 8'h00);
		acc(0, FL, 8'h30);
		rx_rd <= 1'b1;
		rx_full <= 1'b0;
		pulse(4'h0, 0);
		acc(0, FL, 8'h10);
		tx_wr <= 1'b1;
		tx_empty <= 1'b0;
		pulse(4'h0, 0);
		acc(0, FL, 8'h00);
		acc(1, `PIF_OFF_IRQ_CLEAR, 8'hff);
		pulse(4'h4, 1);
		acc(0, `PIF_OFF_IRQ_STATUS, 8'h04);
		chk(evt_irq, 1'b0);
		acc(1, `PIF_OFF_IRQ_ENABLE, 8'h04);
		chk(evt_irq, 1'b1);
		acc(1, `PIF_OFF_IRQ_CLEAR, 8'h04);
		chk(evt_irq, 1'b0);
		acc(0, 8'h40, 8'h00, `PIF_RESP_SLVERR);
		acc(1, 8'h40, 8'h55, `PIF_RESP_SLVERR);
		print_verdict();
	end
endmodule // tb

// ---- verilog/pif_periph_irq.sv ----
// Peripheral interrupt flags, enables, core gating and AXI4-Lite register slave
`timescale 1ns/1ps
`include "pif_defines.svh"

module pif_periph_irq (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_resetn,
	// AXI4-Lite write address
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	// AXI4-Lite write response
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	// AXI4-Lite read data
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// Peripheral events, one-cycle pulses
	input  wire logic        i_timer_a_ovf,
	input  wire logic        i_timer_b_match,
	input  wire logic        i_capcmp_event,
	input  wire logic        i_sync_serial_done,
	// Serial unit buffer state and data register accesses
	input  wire logic        i_serial_rx_full,
	input  wire logic        i_serial_tx_empty,
	input  wire logic        i_serial_rx_data_rd,
	input  wire logic        i_serial_tx_data_wr,
	// Interrupt outputs
	output logic             o_periph_irq,
	output logic             o_evt_irq
);

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	logic               aw_held_ff;
	logic [7:0]         awaddr_ff;
	logic               w_held_ff;
	logic [31:0]        wdata_ff;
	logic [3:0]         wstrb_ff;
	logic               awready_ff;
	logic               wready_ff;
	logic               bvalid_ff;
	logic [1:0]         bresp_ff;
	logic               arready_ff;
	logic               rvalid_ff;
	logic [31:0]        rdata_ff;
	logic [1:0]         rresp_ff;
	logic               wr_fire;
	logic               rd_fire;
	logic               wr_lane0;
	logic               wr_flags;
	logic               wr_enables;
	logic               wr_core_ctrl;
	logic               wr_evt_enable;
	logic               wr_evt_clear;

	pif_pkg::pif_reg8_t flags_ff;
	pif_pkg::pif_reg8_t nxt_flags;
	pif_pkg::pif_reg8_t enables_q;
	pif_pkg::pif_reg8_t core_ctrl_q;
	pif_pkg::pif_reg8_t evt_status_ff;
	pif_pkg::pif_reg8_t evt_enable_ff;
	pif_pkg::pif_reg8_t evt_set;
	pif_pkg::pif_reg8_t wr_byte;
	logic               periph_irq_ff;
	logic               evt_irq_ff;
	logic               rf_we;
	logic               rf_sel;
	pif_pkg::pif_reg8_t rf_wdata;

	function automatic logic addr_known(input logic [7:0] addr);
		addr_known = (addr == `PIF_OFF_FLAGS) || (addr == `PIF_OFF_ENABLES) ||
			(addr == `PIF_OFF_IRQ_STATUS) || (addr == `PIF_OFF_IRQ_ENABLE) ||
			(addr == `PIF_OFF_IRQ_CLEAR) || (addr == `PIF_OFF_CORE_CTRL);
	endfunction

	// Both halves held and no response pending: the write takes effect now
	assign wr_fire  = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_lane0 = wr_fire && wstrb_ff[0];
	assign wr_byte  = wdata_ff[7:0];
	assign rd_fire  = i_arvalid && arready_ff;

	// One write strobe per register except the read-only status register, each qualified by byte lane 0
	assign wr_flags      = wr_lane0 && (awaddr_ff == `PIF_OFF_FLAGS);
	assign wr_enables    = wr_lane0 && (awaddr_ff == `PIF_OFF_ENABLES);
	assign wr_core_ctrl  = wr_lane0 && (awaddr_ff == `PIF_OFF_CORE_CTRL);
	assign wr_evt_enable = wr_lane0 && (awaddr_ff == `PIF_OFF_IRQ_ENABLE);
	assign wr_evt_clear  = wr_lane0 && (awaddr_ff == `PIF_OFF_IRQ_CLEAR);

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			aw_held_ff <= 1'b0;
			awaddr_ff  <= 8'h00;
			awready_ff <= 1'b0;
		end else begin
			// Ready toggles while idle: a lingering valid is never taken twice,
			// at the cost of up to one cycle of extra latency
			awready_ff <= !aw_held_ff && !awready_ff;
			if (i_awvalid && awready_ff) begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= i_awaddr;
				awready_ff <= 1'b0;
			end else if (wr_fire) begin
				aw_held_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			w_held_ff <= 1'b0;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
			wready_ff <= 1'b0;
		end else begin
			wready_ff <= !w_held_ff && !wready_ff;
			if (i_wvalid && wready_ff) begin
				w_held_ff <= 1'b1;
				wdata_ff  <= i_wdata;
				wstrb_ff  <= i_wstrb;
				wready_ff <= 1'b0;
			end else if (wr_fire) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `PIF_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= addr_known(awaddr_ff) ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
		end else if (i_bready && bvalid_ff) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= `PIF_RESP_OKAY;
		end else begin
			// Read data are captured at the address handshake, never later
			arready_ff <= !rvalid_ff && !arready_ff;
			if (rd_fire) begin
				arready_ff <= 1'b0;
				rvalid_ff  <= 1'b1;
				rresp_ff   <= addr_known(i_araddr) ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
				case (i_araddr)
					`PIF_OFF_FLAGS:      rdata_ff <= {24'h000000, flags_ff};
					`PIF_OFF_ENABLES:    rdata_ff <= {24'h000000, enables_q};
					`PIF_OFF_IRQ_STATUS: rdata_ff <= {24'h000000, evt_status_ff};
					`PIF_OFF_IRQ_ENABLE: rdata_ff <= {24'h000000, evt_enable_ff};
					`PIF_OFF_CORE_CTRL:  rdata_ff <= {24'h000000, core_ctrl_q};
					default:             rdata_ff <= 32'h0000_0000;
				endcase
			end else if (i_rready && rvalid_ff) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Enable and core control storage
	// ****************************************************************
	// Serial enable positions are always written as zero, so they cannot read back
	always_comb begin
		rf_we    = wr_enables || wr_core_ctrl;
		rf_sel   = (awaddr_ff == `PIF_OFF_CORE_CTRL);
		rf_wdata = rf_sel ? wr_byte : (wr_byte & ~`PIF_SERIAL_MASK);
	end

	pif_regfile #(
		.WIDTH (8)
	) u_regfile (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_we       (rf_we),
		.i_sel      (rf_sel),
		.i_wdata    (rf_wdata),
		.o_q0       (enables_q),
		.o_q1       (core_ctrl_q)
	);

	// ****************************************************************
	// Event flags
	// ****************************************************************
	always_comb begin
		nxt_flags = flags_ff;
		// Software write loads only the four software-owned flags from the written byte; serial bits are read-only
		if (wr_flags)
			nxt_flags = (flags_ff & ~`PIF_SW_CLR_MASK) | (wr_byte & `PIF_SW_CLR_MASK);
		if (i_sync_serial_done)
			nxt_flags[`PIF_BIT_SYNC_SER] = 1'b1;
		if (i_capcmp_event)
			nxt_flags[`PIF_BIT_CAPCMP] = 1'b1;
		if (i_timer_b_match)
			nxt_flags[`PIF_BIT_TIMER_B] = 1'b1;
		if (i_timer_a_ovf)
			nxt_flags[`PIF_BIT_TIMER_A] = 1'b1;
		nxt_flags[`PIF_BIT_RX_FULL] = i_serial_rx_full && !i_serial_rx_data_rd;
		nxt_flags[`PIF_BIT_TX_EMPTY] = i_serial_tx_empty && !i_serial_tx_data_wr;
		nxt_flags = nxt_flags & ~`PIF_RESV_MASK;
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn)
			flags_ff <= `PIF_REG_RESET;
		else
			flags_ff <= nxt_flags;
	end

	// ****************************************************************
	// Core interrupt request
	// ****************************************************************
	// Peripheral enable and global enable gate
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn)
			periph_irq_ff <= 1'b0;
		else
			periph_irq_ff <= (|(flags_ff & enables_q)) &&
				core_ctrl_q[`PIF_BIT_PERIPH_EN] && core_ctrl_q[`PIF_BIT_GLOBAL_EN];
	end

	// ****************************************************************
	// Event interrupt status
	// ****************************************************************
	// Rising edge of a flag marks an event; set beats a simultaneous clear
	assign evt_set = nxt_flags & ~flags_ff;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			evt_status_ff <= `PIF_REG_RESET;
		end else if (wr_evt_clear) begin
			evt_status_ff <= (evt_status_ff & ~wr_byte) | evt_set;
		end else begin
			evt_status_ff <= evt_status_ff | evt_set;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn)
			evt_enable_ff <= `PIF_REG_RESET;
		else if (wr_evt_enable)
			evt_enable_ff <= wr_byte & ~`PIF_RESV_MASK;
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn)
			evt_irq_ff <= 1'b0;
		else
			evt_irq_ff <= |(evt_status_ff & evt_enable_ff);
	end

	assign o_awready    = awready_ff;
	assign o_wready     = wready_ff;
	assign o_bvalid     = bvalid_ff;
	assign o_bresp      = bresp_ff;
	assign o_arready    = arready_ff;
	assign o_rvalid     = rvalid_ff;
	assign o_rdata      = rdata_ff;
	assign o_rresp      = rresp_ff;
	assign o_periph_irq = periph_irq_ff;
	assign o_evt_irq    = evt_irq_ff;

endmodule // pif_periph_irq

// ---- verilog/pif_regfile.sv ----
// Byte-wide storage for the software-visible enable and core control registers
`timescale 1ns/1ps
`include "pif_defines.svh"

module pif_regfile #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             i_core_clk,
	input  wire logic             i_resetn,
	// Write port
	input  wire logic             i_we,
	input  wire logic             i_sel,
	input  wire logic [WIDTH-1:0] i_wdata,
	// Read port
	output logic      [WIDTH-1:0] o_q0,
	output logic      [WIDTH-1:0] o_q1
);

	logic [WIDTH-1:0] word0_ff;
	logic [WIDTH-1:0] word1_ff;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			word0_ff <= '0;
			word1_ff <= '0;
		end else if (i_we) begin
			if (i_sel)
				word1_ff <= i_wdata;
			else
				word0_ff <= i_wdata;
		end
	end

	assign o_q0 = word0_ff;
	assign o_q1 = word1_ff;

endmodule // pif_regfile
